// ---- dac_link_pkg.sv ----
package dac_link_pkg;
  localparam int unsigned WORD_BITS      = 16;
  localparam int unsigned CTRL_BITS      = 4;
  localparam int unsigned DATA_BITS      = 12;
  localparam int unsigned BYTE_BITS      = 8;
  localparam int unsigned CNT_W          = 5;
  localparam logic [4:0]  CNT_RESET      = 5'h00;
  localparam logic [15:0] SHIFT_RESET    = 16'h0000;
  localparam logic [3:0]  CTRL_RESET     = 4'h0;
  localparam logic [11:0] DATA_RESET     = 12'h000;
  // Control code that moves sampling to the rising edge
  localparam logic [3:0]  CMD_RISE_EDGE  = 4'ha;
  localparam logic [3:0]  CMD_NO_DAISY   = 4'h9;
  // Link clock divider: half period in mclk cycles
  localparam int unsigned LINK_HALF_NS   = 60;
  localparam int unsigned MCLK_NS        = 10;
  localparam int unsigned LINK_HALF_CYC  = LINK_HALF_NS / MCLK_NS;
  localparam int unsigned DIV_W          = 4;
  // Byte pause with frame select held low lasts this many half periods plus one
  localparam int unsigned IDLE_HALVES    = 2;
endpackage

// ---- dac_link_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface dac_link_if;
  logic sclk;
  logic serial_in;
  logic frame_sel_n;
  logic serial_out;
  modport device (input sclk, input serial_in, input frame_sel_n, output serial_out);
  modport host   (output sclk, output serial_in, output frame_sel_n, input serial_out);
endinterface
`default_nettype wire

// ---- dac_link_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module dac_link_host (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic                  send_req,
  input  wire logic [15:0]           send_word,
  input  wire logic                  byte_mode,
  output logic                       send_busy,
  output logic                       send_done,
  output logic [15:0]                readback,
  dac_link_if.host                   link
);
  import dac_link_pkg::*;

  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_SHIFT = 2'b01,
    H_GAP   = 2'b10,
    H_CLOSE = 2'b11
  } host_state_t;

  host_state_t      state_reg;
  logic [DIV_W-1:0] div_reg;
  logic             tick;
  logic [15:0]      tx_reg;
  logic [CNT_W-1:0] bit_reg;
  logic             sclk_reg;
  logic             fs_n_reg;
  logic             sin_reg;
  logic             so_s1_reg;
  logic             so_s2_reg;
  logic [15:0]      rx_reg;
  logic [1:0]       gap_reg;

  assign link.sclk        = sclk_reg;
  assign link.serial_in   = sin_reg;
  assign link.frame_sel_n = fs_n_reg;
  assign tick = (div_reg == DIV_W'(LINK_HALF_CYC - 1));

  ////////////////////////////////////////////////////////////////////
  // Divider makes the link clock from mclk
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_reg <= '0;
    end else if (tick) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      so_s1_reg <= 1'b0;
      so_s2_reg <= 1'b0;
    end else begin
      so_s1_reg <= link.serial_out;
      so_s2_reg <= so_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= H_IDLE;
      sclk_reg  <= 1'b0;
      fs_n_reg  <= 1'b1;
      sin_reg   <= 1'b0;
      tx_reg    <= SHIFT_RESET;
      bit_reg   <= CNT_RESET;
      rx_reg    <= SHIFT_RESET;
      readback  <= SHIFT_RESET;
      send_busy <= 1'b0;
      send_done <= 1'b0;
      gap_reg   <= '0;
    end else begin
      send_done <= 1'b0;
      unique case (state_reg)
        H_IDLE: begin
          if (send_req && tick) begin
            fs_n_reg  <= 1'b0;
            sin_reg   <= send_word[15];
            tx_reg    <= {send_word[14:0], 1'b0};
            bit_reg   <= CNT_RESET;
            send_busy <= 1'b1;
            state_reg <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          if (tick) begin
            sclk_reg <= ~sclk_reg;
            if (sclk_reg) begin
              // change data on the rising half, here at falling done
              bit_reg <= bit_reg + 1'b1;
              rx_reg  <= {rx_reg[14:0], so_s2_reg};
              // one word of sixteen pulses per device
              if (bit_reg == CNT_W'(WORD_BITS - 1)) begin
                state_reg <= H_CLOSE;
              // byte hosts pause with frame select held low
              end else if (byte_mode && bit_reg == CNT_W'(BYTE_BITS - 1)) begin
                gap_reg   <= '0;
                state_reg <= H_GAP;
              end
            end else begin
              // new bit on the rising edge
              if (bit_reg != CNT_RESET) begin
                sin_reg <= tx_reg[15];
                tx_reg  <= {tx_reg[14:0], 1'b0};
              end
            end
          end
        end
        H_GAP: begin
          if (tick) begin
            gap_reg <= gap_reg + 1'b1;
            if (gap_reg == 2'(IDLE_HALVES)) begin
              state_reg <= H_SHIFT;
            end
          end
        end
        H_CLOSE: begin
          if (tick) begin
            // frame select high after last bit
            fs_n_reg  <= 1'b1;
            readback  <= rx_reg;
            send_busy <= 1'b0;
            send_done <= 1'b1;
            state_reg <= H_IDLE;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- dac_link_device.sv ----
`timescale 1ns/10ps
`default_nettype none
// Function
// - Gather one full 16-bit word per frame
// - Link is clock, data, frame select
// - Falling-edge sampling default, control word changes
// - Shift serial_in on falling edge, frame low
// - Update output on frame select rising edge
// - First bit received is the MSB
// - Host changes data on rising edge
// - Host lowers frame select before bits
// - Byte hosts hold frame low between bytes
// - Host raises frame select after last bit
// - Shift register out on rising edges
// - Word is four control, twelve data
// - Frame select fall resets bit counter
// - Early frame edge aborts write standalone
// - Daisy chain needs 16N clock pulses
module dac_link_device (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic                  output_load_n,
  output logic [3:0]                 word_ctrl,
  output logic [11:0]                word_data,
  output logic                       word_valid,
  output logic                       rise_edge_mode,
  output logic                       daisy_mode,
  dac_link_if.device                 link
);
  import dac_link_pkg::*;

  // Link domain: everything below to the crossing runs on sclk or frame select edges
  logic [15:0]      shift_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic             rise_mode_reg;
  logic             daisy_reg;
  logic             sout_reg;
  logic [15:0]      held_reg;
  logic             held_tgl_reg;
  logic [15:0]      shift_next;
  logic             sample_bit_pos;
  logic             sample_bit_neg;
  logic             pos_en;
  logic             neg_en;
  logic             lo_n_s1_reg;
  logic             lo_n_s2_reg;
  logic             frame_lo_seen_reg;
  logic             frame_ack_reg;
  // Count one past a word marks an overlong standalone frame
  localparam logic [CNT_W-1:0] CNT_FIRST = 5'h01;
  localparam logic [CNT_W-1:0] CNT_OVER  = CNT_W'(WORD_BITS + 1);

  // Capture taken on the active edge chosen by the mode bit
  always_ff @(posedge link.sclk or posedge rst) begin
    if (rst) begin
      sample_bit_pos <= 1'b0;
    end else begin
      sample_bit_pos <= link.serial_in;
    end
  end

  assign sample_bit_neg = link.serial_in;
  assign pos_en = rise_mode_reg && !link.frame_sel_n;
  assign neg_en = !rise_mode_reg && !link.frame_sel_n;
  // first bit lands at the top after sixteen shifts
  assign shift_next = {shift_reg[14:0], sample_bit_neg};

  ////////////////////////////////////////////////////////////////////
  // Shift register and counter on falling sclk
  always_ff @(negedge link.sclk or posedge rst) begin
    if (rst) begin
      shift_reg     <= SHIFT_RESET;
      cnt_reg       <= CNT_RESET;
      frame_ack_reg <= 1'b0;
    end else if (!link.frame_sel_n) begin
      // falling edge default, rising mode samples earlier
      if (neg_en) begin
        shift_reg <= shift_next;
      end else if (pos_en) begin
        shift_reg <= {shift_reg[14:0], sample_bit_pos};
      end
      // first shift of a new frame restarts count
      if (frame_ack_reg != frame_lo_seen_reg) begin
        frame_ack_reg <= frame_lo_seen_reg;
        cnt_reg       <= CNT_FIRST;
      // Chain mode wraps per word, so 16N ends on 16
      end else if (cnt_reg == CNT_W'(WORD_BITS)) begin
        cnt_reg <= daisy_reg ? CNT_FIRST : CNT_OVER;
      end else if (cnt_reg != CNT_OVER) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  // readback driven on rising sclk while frame low
  always_ff @(posedge link.sclk or posedge rst) begin
    if (rst) begin
      sout_reg <= 1'b0;
    end else if (!link.frame_sel_n) begin
      sout_reg <= shift_reg[15];
    end
  end
  assign link.serial_out = sout_reg;

  ////////////////////////////////////////////////////////////////////
  // Frame close: frame select rising edge acts as a clock
  always_ff @(posedge link.frame_sel_n or posedge rst) begin
    if (rst) begin
      held_reg      <= SHIFT_RESET;
      held_tgl_reg  <= 1'b0;
      rise_mode_reg <= 1'b0;
      daisy_reg     <= 1'b1;
    // only a complete word is acted on
    // A frame with no shift at all keeps the old count; the ack test drops it
    end else if (frame_ack_reg == frame_lo_seen_reg && cnt_reg == CNT_W'(WORD_BITS)) begin
      // word released on frame select rise
      held_reg     <= shift_reg;
      held_tgl_reg <= ~held_tgl_reg;
      // top four bits are the command
      if (shift_reg[15:12] == CMD_RISE_EDGE) begin
        rise_mode_reg <= 1'b1;
      end
      if (shift_reg[15:12] == CMD_NO_DAISY) begin
        daisy_reg <= 1'b0;
      end
    end
  end

  // counter restart on frame select fall
  // Fall only toggles a flag; the counter lives on sclk, so the first
  // shift that sees the new toggle restarts it. Needs select-to-clock setup.
  always_ff @(negedge link.frame_sel_n or posedge rst) begin
    if (rst) begin
      frame_lo_seen_reg <= 1'b0;
    end else begin
      frame_lo_seen_reg <= ~frame_lo_seen_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Crossing into mclk: toggle event, word stable across it
  logic tgl_s1_reg;
  logic tgl_s2_reg;
  logic tgl_s3_reg;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tgl_s1_reg  <= 1'b0;
      tgl_s2_reg  <= 1'b0;
      tgl_s3_reg  <= 1'b0;
      lo_n_s1_reg <= 1'b1;
      lo_n_s2_reg <= 1'b1;
    end else begin
      tgl_s1_reg  <= held_tgl_reg;
      tgl_s2_reg  <= tgl_s1_reg;
      tgl_s3_reg  <= tgl_s2_reg;
      lo_n_s1_reg <= output_load_n;
      lo_n_s2_reg <= lo_n_s1_reg;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      word_ctrl      <= CTRL_RESET;
      word_data      <= DATA_RESET;
      word_valid     <= 1'b0;
      rise_edge_mode <= 1'b0;
      daisy_mode     <= 1'b1;
    end else begin
      word_valid <= 1'b0;
      // Level copies are safe: they change only with the toggle
      if (tgl_s2_reg != tgl_s3_reg) begin
        word_ctrl      <= held_reg[15:12];
        word_data      <= held_reg[11:0];
        word_valid     <= 1'b1;
        rise_edge_mode <= rise_mode_reg;
        daisy_mode     <= daisy_reg;
      end
    end
  end
endmodule
`default_nettype wire

// ---- dac_link_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
module dac_link_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic serial_in,
  input wire logic frame_sel_n,
  input wire logic serial_out
);
  logic [4:0] falls_reg;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // Falling link edges in the open frame
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      falls_reg <= 5'h00;
    else if ($fell(frame_sel_n))
      falls_reg <= 5'h00;
    else if (!frame_sel_n && $fell(sclk))
      falls_reg <= falls_reg + 5'h01;
  end
  ////////////////////////////////////////
  idle_clk_low_a:
    assert property (frame_sel_n |-> !sclk) else $error("link clock high while idle");
  data_stable_a:
    assert property ($fell(sclk) |-> $stable(serial_in)) else $error("data moved at sample");
  select_setup_a:
    assert property ($fell(frame_sel_n) |-> !sclk) else $error("frame opened with clock high");
  half_period_a:
    assert property ($rose(sclk) |=> sclk [*5]) else $error("link clock high too short");
  clock_runs_a:
    assert property (!frame_sel_n && !sclk && falls_reg != 5'h07 && falls_reg != 5'h08
      |-> ##[1:6] (sclk || frame_sel_n)) else $error("link clock stalled in frame");
  byte_gap_a:
    assert property (!frame_sel_n && !sclk |-> ##[1:24] (sclk || frame_sel_n))
      else $error("byte pause too long");
  word_length_a:
    assert property ($rose(frame_sel_n) |-> falls_reg == 5'h10) else $error("frame not 16 bits");
  readback_edge_a:
    assert property (!frame_sel_n && !$past(frame_sel_n) && $changed(serial_out) |-> $rose(sclk))
      else $error("readback moved off rising edge");
  reset_idle_a:
    assert property ($fell(rst) |-> frame_sel_n && !sclk) else $error("link busy after reset");
  cover property ($rose(frame_sel_n));
  cover property ($fell(frame_sel_n));
  cover property (!frame_sel_n && $changed(serial_out));
endmodule
`default_nettype wire

// ---- dac_serial_word_input_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module dac_serial_word_input_tb_top;
  import dac_link_pkg::*;
  logic        mclk = 1'b0;
  logic        rst;
  logic        send_req = 1'b0;
  logic [15:0] send_word = 16'h0000;
  logic        byte_mode = 1'b0;
  logic        load_n = 1'b1;
  logic        send_busy, send_done, word_valid, rise_edge_mode, daisy_mode;
  logic        valid_b, rise_b, daisy_b;
  logic [15:0] readback;
  logic [3:0]  word_ctrl, ctrl_b;
  logic [11:0] word_data, data_b;
  logic [15:0] prev = 16'h0000;
  logic [15:0] last_b = 16'h0000;
  logic [31:0] w;
  int          miscompares = 0;
  int          n_checks = 0;
  int          seed = 17418;
  int          k;
  dac_link_if u_link ();
  dac_link_if u_link_b ();
  always #5 mclk = ~mclk;
  dac_link_host u_dac_link_host (.mclk(mclk), .rst(rst), .send_req(send_req),
    .send_word(send_word), .byte_mode(byte_mode), .send_busy(send_busy),
    .send_done(send_done), .readback(readback), .link(u_link));
  dac_link_device u_dac_link_device (.mclk(mclk), .rst(rst), .output_load_n(load_n),
    .word_ctrl(word_ctrl), .word_data(word_data), .word_valid(word_valid),
    .rise_edge_mode(rise_edge_mode), .daisy_mode(daisy_mode), .link(u_link));
  // Second device faces a bench driver that breaks framing on purpose
  dac_link_device u_dac_link_device_b (.mclk(mclk), .rst(rst), .output_load_n(load_n),
    .word_ctrl(ctrl_b), .word_data(data_b), .word_valid(valid_b),
    .rise_edge_mode(rise_b), .daisy_mode(daisy_b), .link(u_link_b));
  dac_link_chk u_dac_link_chk (.mclk(mclk), .rst(rst), .sclk(u_link.sclk),
    .serial_in(u_link.serial_in), .frame_sel_n(u_link.frame_sel_n),
    .serial_out(u_link.serial_out));
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  function automatic logic [15:0] field(input logic [15:0] v, input logic ctl);
    return ctl ? {12'h000, v[15:12]} : {4'h0, v[11:0]};
  endfunction
  task automatic send(input logic [15:0] word, input logic bm);
    int i;
    int got;
    got = 0;
    @(negedge mclk);
    send_word = word;
    byte_mode = bm;
    load_n = 1'($random(seed));
    send_req = 1'b1;
    for (i = 0; i < 20 && !send_busy; i++) @(negedge mclk);
    send_req = 1'b0;
    for (i = 0; i < 400 && got < 2; i++) begin
      @(negedge mclk);
      if (send_done === 1'b1) begin
        got++;
        chk("readback", readback, prev);
      end
      if (word_valid === 1'b1) begin
        got++;
        chk("ctrl", 16'(word_ctrl), field(word, 1'b1));
        chk("data", 16'(word_data), field(word, 1'b0));
      end
    end
    if (got < 2) begin
      miscompares++;
      end_of_test();
    end
    chk("busy", 16'(send_busy), 16'h0000);
    prev = word;
  endtask
  // Bench-made link clock, 125 ns period, three pulses before each frame, then one per bit
  task automatic frame_b(input logic [31:0] bits, input int n, input logic ok);
    int i;
    int seen;
    seen = 0;
    for (i = 0; i < 3; i++) begin
      u_link_b.serial_in = ~u_link_b.serial_in;
      #62.5 u_link_b.sclk = 1'b1;
      #62.5 u_link_b.sclk = 1'b0;
    end
    u_link_b.frame_sel_n = 1'b0;
    for (i = n - 1; i >= 0; i--) begin
      #62.5 u_link_b.sclk = 1'b1;
      u_link_b.serial_in = bits[i];
      #62.5 u_link_b.sclk = 1'b0;
    end
    #62.5 u_link_b.frame_sel_n = 1'b1;
    u_link_b.serial_in = ~u_link_b.serial_in;
    for (i = 0; i < 20; i++) begin
      @(negedge mclk);
      if (valid_b === 1'b1) seen = 1;
    end
    if (ok) last_b = bits[15:0];
    chk("accepted", 16'(seen), 16'(ok));
    chk("data_b", 16'(data_b), field(last_b, 1'b0));
    chk("ctrl_b", 16'(ctrl_b), field(last_b, 1'b1));
  endtask
  ////////////////////////////////////////
  initial begin
    rst = 1'b1;
    u_link_b.sclk = 1'b0;
    u_link_b.serial_in = 1'b0;
    u_link_b.frame_sel_n = 1'b1;
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    chk("daisy", 16'(daisy_mode), 16'h0001);
    chk("rise", 16'(rise_edge_mode), 16'h0000);
    chk("ctrl0", 16'(word_ctrl), 16'h0000);
    send(16'h0000, 1'b0);
    send(16'hffff, 1'b1);
    send(16'h8001, 1'b1);
    for (k = 0; k < 12; k++) begin
      w = $random(seed);
      if (k == 6) w[15:12] = 4'h9;
      if (w[15:12] == 4'ha) w[15] = 1'b0;
      send(w[15:0], w[16]);
    end
    chk("standalone", 16'(daisy_mode), 16'h0000);
    // Top bit cleared so the first word cannot leave chain mode
    w = $random(seed);
    w[15] = 1'b0;
    frame_b(w, 16, 1'b1);
    frame_b({$random(seed)} << 16 | 32'h00008abc, 32, 1'b1);
    frame_b($random(seed), 12, 1'b0);
    frame_b(32'h00004321, 16, 1'b1);
    frame_b(32'h00009000, 16, 1'b1);
    frame_b($random(seed), 20, 1'b0);
    frame_b($random(seed), 8, 1'b0);
    frame_b(32'h0000a000, 16, 1'b1);
    chk("rise_b", 16'(rise_b), 16'h0001);
    chk("daisy_b", 16'(daisy_b), 16'h0000);
    end_of_test();
  end
endmodule
`default_nettype wire
